// >>> include/ubpc_pkg.sv
// ubpc_pkg: constants shared by the power/strap device end and its controller.
// assumes a single 40 MHz system clock on both ends.
package ubpc_pkg;
    // clock and reset timing
    localparam int CLK_HZ       = 40_000_000;
    localparam int RST_MIN_NS   = 1000;
    localparam int RST_MIN_CYC  = (RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int RST_HOLD_NS  = 2000;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CR_LOW_CYC   = 2;
    localparam int CR_WAIT_CYC  = 4;
    // device register map, byte offsets within each space
    localparam logic [7:0] OFS_HC_CTRL  = 8'h04;
    localparam logic [7:0] OFS_PM_CFG   = 8'h50;
    localparam logic [7:0] OFS_VSEL_CFG = 8'h52;
    localparam logic       SPACE_CFG    = 1'b0;
    localparam logic       SPACE_OP     = 1'b1;
    localparam int HC_STATE_LSB = 6;
    localparam logic [1:0] HC_SUSPEND   = 2'h3;
    localparam logic [1:0] PM_IO_OFF    = 2'h3;
    localparam int PM_CLKRUN_EN   = 2;
    localparam int PM_CLKRUN_SAVE = 4;
    localparam int VSEL_5V_BIT    = 5;
    localparam logic [31:0] HC_CTRL_RST = 32'h0000_0000;
    localparam logic [7:0]  CFG8_RST    = 8'h00;
    // controller register map, AXI4-Lite byte addresses
    localparam logic [7:0] A_CTRL   = 8'h00;
    localparam logic [7:0] A_CMD    = 8'h04;
    localparam logic [7:0] A_WDATA  = 8'h08;
    localparam logic [7:0] A_RDATA  = 8'h0C;
    localparam logic [7:0] A_STAT   = 8'h10;
    localparam logic [7:0] A_IRQ_ST = 8'h14;
    localparam logic [7:0] A_IRQ_MK = 8'h18;
    localparam int CMD_SPACE_BIT = 8;
    localparam int CMD_WRITE_BIT = 9;
    localparam int CTRL_RST_BIT  = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int IRQ_W = 3;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> include/ubpc_link_if.sv
// ubpc_link_if: pins and register path between controller and device end.
// assumes both ends share CLK_SYS; the clock-run wire is resolved here.
`timescale 1ns/1ps
interface ubpc_link_if;
    logic        sys_rst_n;      // system reset to device, active low
    logic        req;            // register access request, level
    logic        we;
    logic        space;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        ack;            // one-cycle answer
    logic [31:0] rdata;
    logic        h_clkrun_o;
    logic        h_clkrun_oe_n;
    logic        d_clkrun_o;
    logic        d_clkrun_oe_n;
    logic [31:0] ad_o;
    logic        ad_oe_n;
    logic [3:0]  cbe_o;
    logic        cbe_oe_n;
    logic        par_o;
    logic        par_oe_n;
    logic [4:0]  ctl_o;          // frame, irdy, trdy, stop, devsel
    logic [4:0]  ctl_oe_n;
    logic        clkrun_n;
    // a low driver wins; with nobody driving, the pull-up holds it high
    assign clkrun_n = !((!h_clkrun_oe_n && !h_clkrun_o) || (!d_clkrun_oe_n && !d_clkrun_o));
    modport dev  (input sys_rst_n, req, we, space, addr, wdata, clkrun_n,
                  output ack, rdata, d_clkrun_o, d_clkrun_oe_n, ad_o, ad_oe_n,
                  cbe_o, cbe_oe_n, par_o, par_oe_n, ctl_o, ctl_oe_n);
    modport host (output sys_rst_n, req, we, space, addr, wdata, h_clkrun_o, h_clkrun_oe_n,
                  input ack, rdata, clkrun_n);
endinterface

// >>> design/ubpc_dev.sv
// ubpc_dev: power, strap and reset behaviour of the bridge's host side.
// assumes the controller end on the same clock; straps, faults and wake are raw pins.
`timescale 1ns/1ps
module ubpc_dev
#(
    parameter int SYNC_W = 7
)
(
    input  wire logic   CLK_SYS,
    input  wire logic   RST_N,
    ubpc_link_if.dev    LINK,
    input  wire logic   VOLTAGE_SELECT_STRAP,
    input  wire logic   PORT_ONE_OVERCURRENT_IN,
    input  wire logic   PORT_TWO_OVERCURRENT_IN,
    input  wire logic   WAKE_RESUME,
    input  wire logic   WAKE_CONNECT,
    input  wire logic   WAKE_DISCONNECT,
    output logic        CORE_5V_SEL,
    output logic        PORT_ONE_FAULT,
    output logic        PORT_TWO_FAULT,
    output logic        IO_CELLS_OFF,
    output logic        SUSPEND_ACTIVE,
    output logic        CLKRUN_USED
);
    import ubpc_pkg::*;

    typedef enum logic [1:0] {
        UBPC_CR_IDLE = 2'b00,
        UBPC_CR_LOW  = 2'b01,
        UBPC_CR_HIGH = 2'b10
    } ubpc_cr_t;

    if (SYNC_W != 7)
    begin : g_chk
        $error("ubpc_dev: SYNC_W must be 7");
    end

    // two-flop synchronisers; first stage read only by the second
    logic [SYNC_W-1:0] s1_reg;
    logic [SYNC_W-1:0] s2_reg;
    wire  [SYNC_W-1:0] raw_in = {LINK.sys_rst_n, WAKE_DISCONNECT, WAKE_CONNECT, WAKE_RESUME,
                                 PORT_TWO_OVERCURRENT_IN, PORT_ONE_OVERCURRENT_IN,
                                 VOLTAGE_SELECT_STRAP};
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
        end
        else
        begin
            s1_reg <= raw_in;
            s2_reg <= s1_reg;
        end
    end
    wire       vsel_pin = s2_reg[0];
    wire [1:0] oc_pin   = s2_reg[2:1];
    wire [2:0] wake_pin = s2_reg[5:3];
    wire       sysrst_n = s2_reg[6];

    // reset qualification: short glitches do not wipe the registers
    logic [$clog2(RST_MIN_CYC+1)-1:0] rcnt_reg;
    logic [$clog2(RST_MIN_CYC+1)-1:0] rcnt_next;
    wire  long_rst = (rcnt_reg == ($bits(rcnt_reg))'(RST_MIN_CYC));
    wire  in_rst   = !RST_N || long_rst;
    assign rcnt_next = sysrst_n ? '0 : (long_rst ? rcnt_reg : rcnt_reg + 1'b1);
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
            rcnt_reg <= '0;
        else
            rcnt_reg <= rcnt_next;
    end

    // strap capture: tracks pins during reset, freezes at release
    logic [1:0] boot_reg;
    logic       vsel_strap_reg;
    logic [1:0] pol_strap_reg;
    wire  strap_load = in_rst || (boot_reg != 2'h3);
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
            boot_reg <= 2'h0;
        else
            boot_reg <= {boot_reg[0], 1'b1};
    end
    always_ff @(posedge CLK_SYS)
    begin
        if (strap_load)
        begin
            vsel_strap_reg <= vsel_pin;
            pol_strap_reg  <= oc_pin;
        end
    end

    // register access decode
    logic [31:0] hc_ctrl_reg;
    logic [7:0]  pm_cfg_reg;
    logic [7:0]  vsel_cfg_reg;
    logic        vsel_ovr_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    wire  take   = LINK.req && !ack_reg && !in_rst;
    wire  hit_hc = (LINK.space == SPACE_OP)  && (LINK.addr == OFS_HC_CTRL);
    wire  hit_pm = (LINK.space == SPACE_CFG) && (LINK.addr == OFS_PM_CFG);
    wire  hit_vs = (LINK.space == SPACE_CFG) && (LINK.addr == OFS_VSEL_CFG);
    wire  wr     = take && LINK.we;
    wire  [31:0] rd_mux = hit_hc ? hc_ctrl_reg :
                          hit_pm ? {24'h0, pm_cfg_reg} :
                          hit_vs ? {24'h0, vsel_cfg_reg} : 32'h0;

    always_ff @(posedge CLK_SYS)
    begin
        if (in_rst)
        begin
            hc_ctrl_reg  <= HC_CTRL_RST;
            pm_cfg_reg   <= CFG8_RST;
            vsel_cfg_reg <= CFG8_RST;
            vsel_ovr_reg <= 1'b0;
        end
        else if (wr)
        begin
            if (hit_hc)
                hc_ctrl_reg <= LINK.wdata;
            if (hit_pm)
                pm_cfg_reg <= LINK.wdata[7:0];
            if (hit_vs)
            begin
                vsel_cfg_reg <= LINK.wdata[7:0];
                vsel_ovr_reg <= 1'b1;
            end
        end
    end

    // one-cycle answer for every taken request, unmapped reads give zero
    always_ff @(posedge CLK_SYS)
    begin
        if (in_rst)
        begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0;
        end
        else
        begin
            ack_reg <= take;
            if (take && !LINK.we)
                rdata_reg <= rd_mux;
        end
    end
    assign LINK.ack   = ack_reg;
    assign LINK.rdata = rdata_reg;

    // mode decode from the configuration registers
    wire cr_en   = pm_cfg_reg[PM_CLKRUN_EN];
    wire cr_save = pm_cfg_reg[PM_CLKRUN_SAVE];
    wire suspend = (hc_ctrl_reg[HC_STATE_LSB +: 2] == HC_SUSPEND);
    wire io_off  = (pm_cfg_reg[1:0] == PM_IO_OFF);
    // override bit set means 5V; without override a low strap means 5V
    wire sel_5v  = vsel_ovr_reg ? vsel_cfg_reg[VSEL_5V_BIT] : !vsel_strap_reg;
    // strap low: fault active high; strap high: active low
    wire [1:0] fault = oc_pin ^ pol_strap_reg;

    // status outputs from flops; USB clock may only stop once suspended, though the clock-run logic here never looks at the suspend state
    always_ff @(posedge CLK_SYS)
    begin
        if (in_rst)
        begin
            CORE_5V_SEL    <= 1'b0;
            PORT_ONE_FAULT <= 1'b0;
            PORT_TWO_FAULT <= 1'b0;
            IO_CELLS_OFF   <= 1'b0;
            SUSPEND_ACTIVE <= 1'b0;
            CLKRUN_USED    <= 1'b0;
        end
        else
        begin
            CORE_5V_SEL    <= sel_5v;
            PORT_ONE_FAULT <= fault[0];
            PORT_TWO_FAULT <= fault[1];
            IO_CELLS_OFF   <= io_off;
            SUSPEND_ACTIVE <= suspend;
            CLKRUN_USED    <= cr_en;
        end
    end

    // wake is sampled on the system clock, so a stopped USB clock cannot hide it
    logic       wake_d_reg;
    logic       wake_pend_reg;
    wire        wake_any  = |wake_pin;
    wire        wake_rise = wake_any && !wake_d_reg;
    ubpc_cr_t   cr_reg;
    ubpc_cr_t   cr_next;
    logic [1:0] crc_reg;
    wire        cr_want = cr_en && (!cr_save || wake_pend_reg);
    always_comb
    begin
        cr_next = cr_reg;
        case (cr_reg)
            UBPC_CR_IDLE:
                if (cr_want && LINK.clkrun_n)
                    cr_next = UBPC_CR_LOW;
            UBPC_CR_LOW:
                if (crc_reg == 2'(CR_LOW_CYC - 1))
                    cr_next = UBPC_CR_HIGH;
            UBPC_CR_HIGH:
                cr_next = UBPC_CR_IDLE;
            default:
                cr_next = UBPC_CR_IDLE;
        endcase
    end
    always_ff @(posedge CLK_SYS)
    begin
        if (in_rst)
        begin
            cr_reg        <= UBPC_CR_IDLE;
            crc_reg       <= 2'h0;
            wake_d_reg    <= 1'b0;
            wake_pend_reg <= 1'b0;
        end
        else
        begin
            cr_reg     <= cr_next;
            crc_reg    <= (cr_reg == UBPC_CR_LOW) ? crc_reg + 1'b1 : 2'h0;
            wake_d_reg <= wake_any;
            // a new wake in the clearing cycle is kept
            if (wake_rise && cr_en)
                wake_pend_reg <= 1'b1;
            else if (cr_next == UBPC_CR_LOW && cr_reg == UBPC_CR_IDLE)
                wake_pend_reg <= 1'b0;
        end
    end
    // drive low, then high one cycle, then float: sustained tristate
    assign LINK.d_clkrun_o    = (cr_reg == UBPC_CR_HIGH);
    assign LINK.d_clkrun_oe_n = (cr_reg == UBPC_CR_IDLE);

    // bus drive during reset; follows the synced pin, not the 1us qualifier
    wire drive_low = !RST_N || !sysrst_n;
    assign LINK.ad_o     = 32'h0;
    assign LINK.cbe_o    = 4'h0;
    assign LINK.par_o    = 1'b0;
    assign LINK.ad_oe_n  = !drive_low;
    assign LINK.cbe_oe_n = !drive_low;
    assign LINK.par_oe_n = !drive_low;
    // cycle engine lies outside this block, so these never drive
    assign LINK.ctl_o    = 5'h1F;
    assign LINK.ctl_oe_n = 5'h1F;
endmodule

// >>> design/ubpc_host.sv
// ubpc_host: controller end; AXI4-Lite slave, system reset, clock-run master.
// assumes one outstanding AXI read and write; device answers over the link.
`timescale 1ns/1ps
module ubpc_host
(
    input  wire logic                  CLK_SYS,
    input  wire logic                  RST_N,
    ubpc_link_if.host                  LINK,
    input  wire logic [7:0]            S_AXI_AWADDR,
    input  wire logic                  S_AXI_AWVALID,
    output logic                       S_AXI_AWREADY,
    input  wire logic [31:0]           S_AXI_WDATA,
    input  wire logic [3:0]            S_AXI_WSTRB,
    input  wire logic                  S_AXI_WVALID,
    output logic                       S_AXI_WREADY,
    output logic [1:0]                 S_AXI_BRESP,
    output logic                       S_AXI_BVALID,
    input  wire logic                  S_AXI_BREADY,
    input  wire logic [7:0]            S_AXI_ARADDR,
    input  wire logic                  S_AXI_ARVALID,
    output logic                       S_AXI_ARREADY,
    output logic [31:0]                S_AXI_RDATA,
    output logic [1:0]                 S_AXI_RRESP,
    output logic                       S_AXI_RVALID,
    input  wire logic                  S_AXI_RREADY,
    output logic                       IRQ,
    output logic                       HOST_CLOCK_RUNNING
);
    import ubpc_pkg::*;

    typedef enum logic [1:0] {
        UBPC_H_RUN  = 2'b00,
        UBPC_H_DEAS = 2'b01,
        UBPC_H_WAIT = 2'b10,
        UBPC_H_STOP = 2'b11
    } ubpc_hs_t;

    logic              aw_got_reg, w_got_reg;
    logic [7:0]        awaddr_reg;
    logic [31:0]       wdat_reg;
    logic [1:0]        ctrl_reg;
    logic [9:0]        cmd_reg;
    logic [31:0]       wdata_reg, rdata_reg;
    logic [IRQ_W-1:0]  ist_reg, imask_reg;
    logic              req_reg;
    logic [$clog2(RST_HOLD_CYC+1)-1:0] rcnt_reg;
    ubpc_hs_t          hs_reg, hs_next;
    logic [2:0]        wcnt_reg;

    // write path: address and data may arrive in either order
    wire do_wr  = aw_got_reg && w_got_reg && !S_AXI_BVALID;
    wire wr_ok  = (awaddr_reg == A_CTRL) || (awaddr_reg == A_CMD) || (awaddr_reg == A_WDATA)
               || (awaddr_reg == A_IRQ_MK);
    wire go_cmd = do_wr && (awaddr_reg == A_CMD) && !req_reg;
    assign S_AXI_AWREADY = !aw_got_reg && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_got_reg && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    wire rd_take = S_AXI_ARVALID && S_AXI_ARREADY;
    wire rst_on  = (rcnt_reg != '0);
    wire [IRQ_W-1:0] ev;
    wire [31:0] rd_mux = (S_AXI_ARADDR == A_CTRL)   ? {30'h0, ctrl_reg} :
                         (S_AXI_ARADDR == A_CMD)    ? {22'h0, cmd_reg} :
                         (S_AXI_ARADDR == A_WDATA)  ? wdata_reg :
                         (S_AXI_ARADDR == A_RDATA)  ? rdata_reg :
                         (S_AXI_ARADDR == A_STAT)   ? {28'h0, HOST_CLOCK_RUNNING,
                                                       LINK.clkrun_n, rst_on, req_reg} :
                         (S_AXI_ARADDR == A_IRQ_ST) ? {29'h0, ist_reg} :
                         (S_AXI_ARADDR == A_IRQ_MK) ? {29'h0, imask_reg} : 32'h0;
    wire rd_ok = (S_AXI_ARADDR <= A_IRQ_MK) && (S_AXI_ARADDR[1:0] == 2'h0);

    // bus handshake state
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= 8'h0;
            wdat_reg   <= 32'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RRESP  <= RESP_OKAY;
            S_AXI_RDATA  <= 32'h0;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_got_reg <= 1'b1;
                awaddr_reg <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_got_reg <= 1'b1;
                wdat_reg  <= S_AXI_WDATA;
            end
            if (do_wr)
            begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
            if (rd_take)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_mux;
                S_AXI_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

    // registers; strobes ignored, every write loads its whole field but CTRL's reset bit, including the 10-bit command (dropped while pending) and 32-bit data
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            ctrl_reg  <= 2'h0;
            cmd_reg   <= 10'h0;
            wdata_reg <= 32'h0;
            imask_reg <= '0;
            rdata_reg <= 32'h0;
            req_reg   <= 1'b0;
            rcnt_reg  <= ($bits(rcnt_reg))'(RST_HOLD_CYC);
        end
        else
        begin
            if (do_wr && awaddr_reg == A_CTRL)
                ctrl_reg <= {wdat_reg[CTRL_STOP_BIT], 1'b0};
            if (do_wr && awaddr_reg == A_WDATA)
                wdata_reg <= wdat_reg;
            if (do_wr && awaddr_reg == A_IRQ_MK)
                imask_reg <= wdat_reg[IRQ_W-1:0];
            if (go_cmd)
            begin
                cmd_reg <= wdat_reg[9:0];
                req_reg <= 1'b1;
            end
            else if (LINK.ack)
            begin
                req_reg <= 1'b0;
                if (!cmd_reg[CMD_WRITE_BIT])
                    rdata_reg <= LINK.rdata;
            end
            // a reset pulse is always held longer than the device's minimum
            if (do_wr && awaddr_reg == A_CTRL && wdat_reg[CTRL_RST_BIT])
                rcnt_reg <= ($bits(rcnt_reg))'(RST_HOLD_CYC);
            else if (rst_on)
                rcnt_reg <= rcnt_reg - 1'b1;
        end
    end
    assign LINK.sys_rst_n = !rst_on;
    assign LINK.req   = req_reg;
    assign LINK.we    = cmd_reg[CMD_WRITE_BIT];
    assign LINK.space = cmd_reg[CMD_SPACE_BIT];
    assign LINK.addr  = cmd_reg[7:0];
    assign LINK.wdata = wdata_reg;

    // clock-run master: hold low while running, stop only if nobody objects
    always_comb
    begin
        hs_next = hs_reg;
        case (hs_reg)
            UBPC_H_RUN:
                if (ctrl_reg[CTRL_STOP_BIT])
                    hs_next = UBPC_H_DEAS;
            UBPC_H_DEAS:
                hs_next = UBPC_H_WAIT;
            UBPC_H_WAIT:
                if (!LINK.clkrun_n)
                    hs_next = UBPC_H_RUN;
                else if (wcnt_reg == 3'(CR_WAIT_CYC - 1))
                    hs_next = UBPC_H_STOP;
            UBPC_H_STOP:
                if (!LINK.clkrun_n || !ctrl_reg[CTRL_STOP_BIT])
                    hs_next = UBPC_H_RUN;
            default:
                hs_next = UBPC_H_RUN;
        endcase
    end
    assign ev = {(rcnt_reg == 1),
                 (hs_reg == UBPC_H_STOP) && !LINK.clkrun_n,
                 LINK.ack};
    wire clr_ist = rd_take && (S_AXI_ARADDR == A_IRQ_ST);
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            hs_reg   <= UBPC_H_RUN;
            wcnt_reg <= 3'h0;
            ist_reg  <= '0;
            HOST_CLOCK_RUNNING <= 1'b1;
        end
        else
        begin
            hs_reg   <= hs_next;
            wcnt_reg <= (hs_reg == UBPC_H_WAIT) ? wcnt_reg + 1'b1 : 3'h0;
            HOST_CLOCK_RUNNING <= (hs_next != UBPC_H_STOP);
            // set wins over the read clear
            ist_reg  <= (clr_ist ? '0 : ist_reg) | ev;
        end
    end
    assign LINK.h_clkrun_o    = (hs_reg == UBPC_H_DEAS);
    assign LINK.h_clkrun_oe_n = (hs_reg == UBPC_H_WAIT) || (hs_reg == UBPC_H_STOP);
    assign IRQ = |(ist_reg & imask_reg);
endmodule

// >>> verif/ubpc_chk.sv
// ubpc_chk: link-level checks between the controller and the device end.
// assumes interface signals wired in by name; one clock domain.
`timescale 1ns/1ps
module ubpc_chk
    import ubpc_pkg::*;
(
    input wire logic        CLK_SYS,
    input wire logic        RST_N,
    input wire logic        sys_rst_n,
    input wire logic        req,
    input wire logic        ack,
    input wire logic [31:0] ad_o,
    input wire logic        ad_oe_n,
    input wire logic        cbe_oe_n,
    input wire logic        par_oe_n,
    input wire logic [4:0]  ctl_oe_n,
    input wire logic        d_clkrun_o,
    input wire logic        d_clkrun_oe_n,
    input wire logic        h_clkrun_o,
    input wire logic        h_clkrun_oe_n
);
    logic [7:0] low_cnt;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    // run length of system reset; saturates so a stuck reset cannot wrap
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N || sys_rst_n)
            low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF)
            low_cnt <= low_cnt + 8'h01;
    end
    // sync delay of two flops is allowed for before each bus check
    property p_bus_low; !sys_rst_n [*4] |-> {ad_oe_n, cbe_oe_n, par_oe_n, ad_o} == 35'h0; endproperty
    property p_bus_free; sys_rst_n [*4] |-> ad_oe_n && cbe_oe_n && par_oe_n; endproperty
    property p_ctl_float; ctl_oe_n == 5'h1F; endproperty
    property p_ack_answer; $rose(req) |-> ##[1:2] ack; endproperty
    property p_quiet_reset; !sys_rst_n [*4] |-> !ack; endproperty
    property p_reset_len; $rose(sys_rst_n) |-> int'(low_cnt) >= RST_MIN_CYC; endproperty
    property p_dev_clkrun;
        $fell(d_clkrun_oe_n) && $past(RST_N) |-> (!d_clkrun_o && !d_clkrun_oe_n) [*2]
            ##1 (d_clkrun_o && !d_clkrun_oe_n) ##1 d_clkrun_oe_n;
    endproperty
    property p_host_clkrun; $rose(h_clkrun_oe_n) && $past(RST_N) |-> $past(h_clkrun_o); endproperty
    a_bus_low: assert property (p_bus_low) else $error("bus not low in reset");
    a_bus_free: assert property (p_bus_free) else $error("bus not released");
    a_ctl_float: assert property (p_ctl_float) else $error("control line driven");
    a_ack_answer: assert property (p_ack_answer) else $error("no link answer");
    a_quiet_reset: assert property (p_quiet_reset) else $error("ack in reset");
    a_reset_len: assert property (p_reset_len) else $error("reset too short");
    a_dev_clkrun: assert property (p_dev_clkrun) else $error("bad device clkrun");
    a_host_clkrun: assert property (p_host_clkrun) else $error("host left low");
    c_ack: cover property (ack);
    c_dev_clkrun: cover property ($fell(d_clkrun_oe_n));
    c_reset_done: cover property ($rose(sys_rst_n));
endmodule

// >>> verif/ubpc_tb_top.sv
// ubpc_tb_top: drives the controller over AXI4-Lite and watches the device end's pins.
// assumes both ends joined by one link interface on a single 40 MHz clock.
`timescale 1ns/1ps
module ubpc_tb_top;
    import ubpc_pkg::*;
    logic        clk_sys, rst_n, vsel, oc1, oc2, awv, wv, brdy, arv, rrdy;
    logic [2:0]  wake;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd;
    logic [1:0]  br, rr;
    logic        awr, wr, bv, arr, rv, irq, hrun, c5v, f1, f2, ioff, susp, cru;
    int          bad_count, n_checks, cyc;
    logic [7:0]  pm_tab [5] = '{8'h14, 8'h14, 8'h14, 8'h04, 8'h10};
    ubpc_link_if link ();
    ubpc_dev u_ubpc_dev (.CLK_SYS(clk_sys), .RST_N(rst_n), .LINK(link.dev),
        .VOLTAGE_SELECT_STRAP(vsel), .PORT_ONE_OVERCURRENT_IN(oc1),
        .PORT_TWO_OVERCURRENT_IN(oc2), .WAKE_RESUME(wake[0]), .WAKE_CONNECT(wake[1]),
        .WAKE_DISCONNECT(wake[2]), .CORE_5V_SEL(c5v), .PORT_ONE_FAULT(f1), .PORT_TWO_FAULT(f2),
        .IO_CELLS_OFF(ioff), .SUSPEND_ACTIVE(susp), .CLKRUN_USED(cru));
    ubpc_host u_ubpc_host (.CLK_SYS(clk_sys), .RST_N(rst_n), .LINK(link.host),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rrdy), .IRQ(irq), .HOST_CLOCK_RUNNING(hrun));
    ubpc_chk u_ubpc_chk (.CLK_SYS(clk_sys), .RST_N(rst_n), .sys_rst_n(link.sys_rst_n),
        .req(link.req), .ack(link.ack), .ad_o(link.ad_o), .ad_oe_n(link.ad_oe_n),
        .cbe_oe_n(link.cbe_oe_n), .par_oe_n(link.par_oe_n), .ctl_oe_n(link.ctl_oe_n),
        .d_clkrun_o(link.d_clkrun_o), .d_clkrun_oe_n(link.d_clkrun_oe_n),
        .h_clkrun_o(link.h_clkrun_o), .h_clkrun_oe_n(link.h_clkrun_oe_n));
    // clock and hang guard; the ceiling is far above the expected run
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [33:0] got, input logic [33:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // each channel is released on its own handshake edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awa <= a;
        wd <= d;
        {awv, wv} <= 2'b11;
        do
        begin
            @(posedge clk_sys);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        check({br, 32'h0}, {er, 32'h0});
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] er);
        ara <= a;
        arv <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            if (arr) arv <= 1'b0;
        end while (!rv);
        check({rr, rd & m}, {er, e});
    endtask
    // completion is seen through the unmasked access-done interrupt, then cleared
    task automatic dev_op(input logic [9:0] cmd, input logic [31:0] d);
        axi_wr(A_WDATA, d, RESP_OKAY);
        axi_wr(A_CMD, {22'h0, cmd}, RESP_OKAY);
        for (int i = 0; i < 40 && !irq; i++) @(posedge clk_sys);
        axi_rd(A_IRQ_ST, 32'h1, 32'h1, RESP_OKAY);
    endtask
    task automatic dev_rd(input logic sp, input logic [7:0] a, input logic [31:0] m, e);
        dev_op({1'b0, sp, a}, 32'h0);
        axi_rd(A_RDATA, m, e, RESP_OKAY);
    endtask
    task automatic wait_sys;
        for (int i = 0; i < 200 && link.sys_rst_n !== 1'b0; i++) @(posedge clk_sys);
        for (int i = 0; i < 200 && link.sys_rst_n !== 1'b1; i++) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
        axi_rd(A_IRQ_ST, 32'h4, 32'h4, RESP_OKAY);
    endtask
    initial
    begin
        {clk_sys, rst_n, vsel, oc1, oc2, wake, brdy, rrdy} = 10'b0000_1000_11;
        {awa, ara, wd, awv, wv, arv} = '0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        wait_sys();
        check({33'h0, c5v}, 34'h1);
        check({32'h0, f2, f1}, 34'h0);
        {oc1, oc2} <= 2'b10;
        repeat (4) @(posedge clk_sys);
        check({32'h0, f2, f1}, 34'h3);
        {oc1, oc2} <= 2'b01;
        axi_wr(A_IRQ_MK, 32'h1, RESP_OKAY);
        axi_wr(8'h1C, 32'h5, RESP_SLVERR);
        axi_rd(8'h02, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
        dev_rd(SPACE_OP, OFS_HC_CTRL, 32'hFFFF_FFFF, HC_CTRL_RST);
        dev_op({2'b10, OFS_VSEL_CFG}, 32'h00);
        check({33'h0, c5v}, 34'h0);
        dev_op({2'b10, OFS_VSEL_CFG}, 32'h20);
        check({33'h0, c5v}, 34'h1);
        for (int v = 0; v < 4; v++)
        begin
            dev_op({2'b10, OFS_PM_CFG}, 32'(v));
            check({33'h0, ioff}, {33'h0, v == 3});
        end
        dev_op({2'b11, OFS_HC_CTRL}, 32'hC0);
        check({33'h0, susp}, 34'h1);
        dev_op({2'b11, OFS_HC_CTRL}, 32'h80);
        check({33'h0, susp}, 34'h0);
        // strap now reads 3.3V, so only a cleared override gives 0
        vsel <= 1'b1;
        axi_wr(A_CTRL, 32'h1, RESP_OKAY);
        wait_sys();
        check({32'h0, c5v, ioff}, 34'h0);
        dev_rd(SPACE_CFG, OFS_VSEL_CFG, 32'hFF, {24'h0, CFG8_RST});
        dev_op({2'b11, OFS_HC_CTRL}, 32'hC0);
        // stop the bus clock, then wake through each event kind
        for (int i = 0; i < 5; i++)
        begin
            dev_op({2'b10, OFS_PM_CFG}, {24'h0, pm_tab[i]});
            check({33'h0, cru}, {33'h0, pm_tab[i][2]});
            axi_wr(A_CTRL, 32'h2, RESP_OKAY);
            for (int n = 0; n < 30 && hrun; n++) @(posedge clk_sys);
            check({33'h0, hrun}, {33'h0, pm_tab[i] == 8'h04});
            wake <= 3'(1 << (i % 3));
            repeat (4) @(posedge clk_sys);
            wake <= 3'b000;
            for (int n = 0; n < 30 && !hrun; n++) @(posedge clk_sys);
            check({33'h0, hrun, irq}, {33'h0, pm_tab[i][2], 1'b0});
            axi_rd(A_IRQ_ST, 32'h2, {30'h0, pm_tab[i] == 8'h14, 1'b0}, RESP_OKAY);
            axi_wr(A_CTRL, 32'h0, RESP_OKAY);
        end
        summarize();
    end
endmodule
